// ---- core/dss_pkg.sv ----
// Package: register map, field positions and reset values of the status/error register bank
package dss_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_PIN_CONTROL_LOW_OFS = 8'h0E;
  localparam logic [7:0] DETECTED_ERROR_THRESHOLD_OFS = 8'h0F;
  localparam logic [7:0] DETECTED_ERROR_COUNT_OFS = 8'h10;
  localparam logic [7:0] CORRECTED_ERROR_THRESHOLD_OFS = 8'h11;
  localparam logic [7:0] CORRECTED_ERROR_COUNT_OFS = 8'h12;
  localparam logic [7:0] SEQUENCE_ERROR_COUNT_OFS = 8'h13;
  localparam logic [7:0] SEQUENCE_TEST_RESULT_OFS = 8'h14;
  localparam logic [7:0] RESERVED_A_OFS = 8'h15;
  localparam logic [7:0] RESERVED_B_OFS = 8'h16;
  localparam logic [7:0] RESERVED_C_OFS = 8'h17;
  localparam logic [7:0] RESERVED_D_OFS = 8'h18;
  localparam logic [7:0] RESERVED_E_OFS = 8'h19;
  localparam logic [7:0] RESERVED_F_OFS = 8'h1A;
  localparam logic [7:0] RESERVED_G_OFS = 8'h1B;
  localparam logic [7:0] RESERVED_H_OFS = 8'h1C;
  localparam logic [7:0] STRAP_PIN_STATUS_OFS = 8'h1D;
  localparam logic [7:0] PART_IDENTIFIER_OFS = 8'h1E;
  localparam logic [7:0] CAPABILITY_AND_REVISION_OFS = 8'h1F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned AUX_PIN0_LEVEL_BIT = 0;
  localparam int unsigned AUX_PIN0_DRIVE_BIT = 1;
  localparam int unsigned AUX_PIN1_LEVEL_BIT = 2;
  localparam int unsigned SEQUENCE_TEST_PASSED_BIT = 7;
  localparam int unsigned STRAP_LSB = 4;
  localparam int unsigned PROTECTION_CAPABILITY_BIT = 4;
  localparam int unsigned REVISION_LSB = 0;
  localparam int unsigned REVISION_W = 4;

  // ----------------------------------------------------------------
  // Reset, counter saturation and fixed read values
  // ----------------------------------------------------------------
  localparam logic AUX_PIN0_DRIVE_RST = 1'b1;
  localparam logic [7:0] THRESHOLD_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] RESERVED_A_VAL = 8'h20;
  localparam logic [7:0] RESERVED_B_VAL = 8'h30;
  localparam logic [7:0] RESERVED_C_VAL = 8'h54;
  localparam logic [7:0] RESERVED_D_VAL = 8'h30;
  localparam logic [7:0] RESERVED_E_VAL = 8'hC8;
  localparam logic [7:0] RESERVED_ZERO_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;

  // ----------------------------------------------------------------
  // Identity defaults (arbitrary values)
  // ----------------------------------------------------------------
  localparam logic [7:0] PART_ID_DEFAULT = 8'h5C;
  localparam logic [3:0] REVISION_DEFAULT = 4'h1;

  // ----------------------------------------------------------------
  // Synchroniser depth
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;

endpackage

// ---- core/dss_sync.sv ----
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none

module dss_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// ---- core/dss_status_regs.sv ----
// Status, error-counter, strap and identity register bank of the link deserializer
`timescale 1ns/100ps
`default_nettype none

module dss_status_regs
  import dss_pkg::*;
#(
  parameter logic [7:0] PART_ID = PART_ID_DEFAULT,
  parameter logic [3:0] REVISION = REVISION_DEFAULT,
  parameter logic PROTECTION_CAPABLE = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_aux_pin0,
  output logic o_aux_pin0_drive,
  output logic o_aux_pin0_oe,
  input wire logic i_aux_pin1,
  input wire logic i_cable_type_strap,
  input wire logic i_coax_select_strap,
  input wire logic i_control_port_select_strap,
  input wire logic i_local_channel_enable_strap,
  input wire logic i_detected_error,
  input wire logic i_corrected_error,
  input wire logic i_sequence_error,
  input wire logic i_sequence_test_passed,
  output logic [DATA_W-1:0] o_detected_error_threshold,
  output logic [DATA_W-1:0] o_corrected_error_threshold,
  output logic o_detected_over_threshold,
  output logic o_corrected_over_threshold
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [5:0] pins_raw;
  logic [5:0] pins_s;
  logic aux_pin0_level;
  logic aux_pin1_level;
  logic [3:0] strap_level;

  assign pins_raw = {i_cable_type_strap, i_coax_select_strap, i_control_port_select_strap,
                     i_local_channel_enable_strap, i_aux_pin1, i_aux_pin0};

  dss_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async(pins_raw),
    .o_sync(pins_s)
  );

  assign aux_pin0_level = pins_s[0];
  assign aux_pin1_level = pins_s[1];
  assign strap_level = pins_s[5:2];

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_pin;
  logic wr_det_thr;
  logic wr_corr_thr;

  assign wr_pin = i_wr && (i_addr == AUX_PIN_CONTROL_LOW_OFS);
  assign wr_det_thr = i_wr && (i_addr == DETECTED_ERROR_THRESHOLD_OFS);
  assign wr_corr_thr = i_wr && (i_addr == CORRECTED_ERROR_THRESHOLD_OFS);

  // ----------------------------------------------------------------
  // Pin 0 drive
  // ----------------------------------------------------------------
  logic aux_pin0_drive_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aux_pin0_drive_q <= AUX_PIN0_DRIVE_RST;
    end else if (wr_pin) begin
      aux_pin0_drive_q <= i_wdata[AUX_PIN0_DRIVE_BIT];
    end
  end

  // Push-pull driver; the level bit reads back the wire, not this register
  assign o_aux_pin0_drive = aux_pin0_drive_q;
  assign o_aux_pin0_oe = 1'b1;

  // ----------------------------------------------------------------
  // Thresholds
  // ----------------------------------------------------------------
  logic [7:0] det_thr_q;
  logic [7:0] corr_thr_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      det_thr_q <= THRESHOLD_RST;
    end else if (wr_det_thr) begin
      det_thr_q <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      corr_thr_q <= THRESHOLD_RST;
    end else if (wr_corr_thr) begin
      corr_thr_q <= i_wdata;
    end
  end

  assign o_detected_error_threshold = det_thr_q;
  assign o_corrected_error_threshold = corr_thr_q;

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  // Counters saturate so a long error burst never wraps to a small value
  logic [7:0] det_cnt_q;
  logic [7:0] corr_cnt_q;
  logic [7:0] seq_cnt_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      det_cnt_q <= COUNT_RST;
    end else if (i_detected_error && (det_cnt_q != COUNT_MAX)) begin
      det_cnt_q <= det_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      corr_cnt_q <= COUNT_RST;
    end else if (i_corrected_error && (corr_cnt_q != COUNT_MAX)) begin
      corr_cnt_q <= corr_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      seq_cnt_q <= COUNT_RST;
    end else if (i_sequence_error && (seq_cnt_q != COUNT_MAX)) begin
      seq_cnt_q <= seq_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Threshold flags
  // ----------------------------------------------------------------
  // A zero threshold disables the flag
  logic det_over_q;
  logic corr_over_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      det_over_q <= 1'b0;
      corr_over_q <= 1'b0;
    end else begin
      det_over_q <= (det_thr_q != THRESHOLD_RST) && (det_cnt_q >= det_thr_q);
      corr_over_q <= (corr_thr_q != THRESHOLD_RST) && (corr_cnt_q >= corr_thr_q);
    end
  end

  assign o_detected_over_threshold = det_over_q;
  assign o_corrected_over_threshold = corr_over_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  always_comb begin
    rd_mux = UNMAPPED_VAL;
    case (i_addr)
      AUX_PIN_CONTROL_LOW_OFS: begin
        rd_mux[AUX_PIN1_LEVEL_BIT] = aux_pin1_level;
        rd_mux[AUX_PIN0_DRIVE_BIT] = aux_pin0_drive_q;
        rd_mux[AUX_PIN0_LEVEL_BIT] = aux_pin0_level;
      end
      DETECTED_ERROR_THRESHOLD_OFS: rd_mux = det_thr_q;
      DETECTED_ERROR_COUNT_OFS: rd_mux = det_cnt_q;
      CORRECTED_ERROR_THRESHOLD_OFS: rd_mux = corr_thr_q;
      CORRECTED_ERROR_COUNT_OFS: rd_mux = corr_cnt_q;
      SEQUENCE_ERROR_COUNT_OFS: rd_mux = seq_cnt_q;
      SEQUENCE_TEST_RESULT_OFS: begin
        rd_mux[SEQUENCE_TEST_PASSED_BIT] = i_sequence_test_passed;
      end
      RESERVED_A_OFS: rd_mux = RESERVED_A_VAL;
      RESERVED_B_OFS: rd_mux = RESERVED_B_VAL;
      RESERVED_C_OFS: rd_mux = RESERVED_C_VAL;
      RESERVED_D_OFS: rd_mux = RESERVED_D_VAL;
      RESERVED_E_OFS: rd_mux = RESERVED_E_VAL;
      RESERVED_F_OFS: rd_mux = RESERVED_ZERO_VAL;
      RESERVED_G_OFS: rd_mux = RESERVED_ZERO_VAL;
      RESERVED_H_OFS: rd_mux = RESERVED_ZERO_VAL;
      STRAP_PIN_STATUS_OFS: begin
        rd_mux[STRAP_LSB +: 4] = strap_level;
      end
      PART_IDENTIFIER_OFS: rd_mux = PART_ID;
      CAPABILITY_AND_REVISION_OFS: begin
        rd_mux[PROTECTION_CAPABILITY_BIT] = PROTECTION_CAPABLE;
        rd_mux[REVISION_LSB +: REVISION_W] = REVISION;
      end
      default: rd_mux = UNMAPPED_VAL;
    endcase
  end

  // Data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence rd_at(logic [7:0] ofs);
    i_rd && (i_addr == ofs);
  endsequence

  sequence wr_at(logic [7:0] ofs);
    i_wr && (i_addr == ofs);
  endsequence

  pin1_level_read_a: assert property (
    rd_at(AUX_PIN_CONTROL_LOW_OFS) |=> (o_rdata[2] == $past(aux_pin1_level)) && (o_rdata[7:3] == 5'h00))
    else $error("pin 1 level not returned on bit 2");

  pin0_drive_write_a: assert property (
    wr_at(AUX_PIN_CONTROL_LOW_OFS) ##1 rd_at(AUX_PIN_CONTROL_LOW_OFS)
      |=> (o_rdata[1] == $past(i_wdata[1], 2)) && (o_aux_pin0_drive == o_rdata[1]))
    else $error("pin 0 drive bit not written or read back");

  pin0_level_read_a: assert property (
    rd_at(AUX_PIN_CONTROL_LOW_OFS) |=> o_rdata[0] == $past(aux_pin0_level))
    else $error("pin 0 level not returned on bit 0");

  det_thr_write_a: assert property (
    wr_at(DETECTED_ERROR_THRESHOLD_OFS) ##1 rd_at(DETECTED_ERROR_THRESHOLD_OFS)
      |=> o_rdata == $past(i_wdata, 2))
    else $error("detected threshold write lost");

  corr_thr_write_a: assert property (
    wr_at(CORRECTED_ERROR_THRESHOLD_OFS) |=> o_corrected_error_threshold == $past(i_wdata))
    else $error("corrected threshold write lost");

  seq_result_read_a: assert property (
    rd_at(SEQUENCE_TEST_RESULT_OFS) |=> (o_rdata[7] == $past(i_sequence_test_passed)) && (o_rdata[6:0] == 7'h00))
    else $error("sequence test result misread");

  strap_read_a: assert property (
    rd_at(STRAP_PIN_STATUS_OFS) |=> (o_rdata[7:4] == $past(strap_level)) && (o_rdata[3:0] == 4'h0))
    else $error("strap status misread");

  counter_write_ignored_a: assert property (
    (wr_at(DETECTED_ERROR_COUNT_OFS) or wr_at(CORRECTED_ERROR_COUNT_OFS) or wr_at(SEQUENCE_ERROR_COUNT_OFS))
      and (!i_detected_error && !i_corrected_error && !i_sequence_error)
      |=> $stable(det_cnt_q) && $stable(corr_cnt_q) && $stable(seq_cnt_q))
    else $error("error counter changed by a write");

  counter_step_a: assert property (
    i_detected_error && (det_cnt_q != COUNT_MAX) |=> det_cnt_q == $past(det_cnt_q) + 8'h01)
    else $error("detected counter did not step");

  corr_cnt_step_a: assert property (
    i_corrected_error && (corr_cnt_q != COUNT_MAX) |=> corr_cnt_q == $past(corr_cnt_q) + 8'h01)
    else $error("corrected counter did not step");

  seq_cnt_step_a: assert property (
    i_sequence_error && (seq_cnt_q != COUNT_MAX) |=> seq_cnt_q == $past(seq_cnt_q) + 8'h01)
    else $error("sequence counter did not step");

  counter_hold_a: assert property (
    !i_detected_error && !i_corrected_error && !i_sequence_error
      |=> $stable(det_cnt_q) && $stable(corr_cnt_q) && $stable(seq_cnt_q))
    else $error("error counter moved without an event");

  det_thr_out_a: assert property (
    wr_at(DETECTED_ERROR_THRESHOLD_OFS) |=> o_detected_error_threshold == $past(i_wdata))
    else $error("detected threshold output not updated");

endmodule

`default_nettype wire

// ---- test/dss_host_model.sv ----
// Register-bus master model standing in for the remote controller
`timescale 1ns/100ps
`default_nettype none

module dss_host_model
  import dss_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic [DATA_W-1:0] i_rdata,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  // Write data inverted on release, so a stale value is never taken as live
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    // Let the write settle before the caller looks at outputs
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule

`default_nettype wire

// ---- test/dss_status_regs_tb.sv ----
// Self-checking testbench of the status and error register bank
`timescale 1ns/100ps
`default_nettype none

module dss_status_regs_tb
  import dss_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr, wdata, rdata, det_thr, cor_thr;
  logic wr, rd, drv, oe, det_over, cor_over;
  logic pin0 = 1'b0, pin1 = 1'b0;
  logic [3:0] strap = 4'h0;
  logic det_ev = 1'b0, cor_ev = 1'b0, seq_ev = 1'b0, seq_ok = 1'b0;
  int n_errors = 0;
  int check_count = 0;

  always #4 clk = ~clk;

  dss_host_model dss_host_model_i (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));

  dss_status_regs dss_status_regs_i (.i_sys_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_aux_pin0(pin0), .o_aux_pin0_drive(drv), .o_aux_pin0_oe(oe),
    .i_aux_pin1(pin1), .i_cable_type_strap(strap[3]), .i_coax_select_strap(strap[2]),
    .i_control_port_select_strap(strap[1]), .i_local_channel_enable_strap(strap[0]),
    .i_detected_error(det_ev), .i_corrected_error(cor_ev), .i_sequence_error(seq_ev),
    .i_sequence_test_passed(seq_ok), .o_detected_error_threshold(det_thr),
    .o_corrected_error_threshold(cor_thr), .o_detected_over_threshold(det_over),
    .o_corrected_over_threshold(cor_over));

  // ----------------------------------------------------------------
  // Shared checking
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    dss_host_model_i.rd(a, d);
    check(name, exp, d);
  endtask

  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge clk);
      case (which)
        0: det_ev <= 1'b1;
        1: cor_ev <= 1'b1;
        default: seq_ev <= 1'b1;
      endcase
    end
    @(posedge clk);
    det_ev <= 1'b0;
    cor_ev <= 1'b0;
    seq_ev <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk("pin reg", AUX_PIN_CONTROL_LOW_OFS, 8'h02);
    check("pin0 drive", 8'h01, {7'h00, drv});
    check("pin0 oe", 8'h01, {7'h00, oe});
    rd_chk("det thr", DETECTED_ERROR_THRESHOLD_OFS, 8'h00);
    rd_chk("cor thr", CORRECTED_ERROR_THRESHOLD_OFS, 8'h00);
    for (int a = 8'h10; a <= 8'h13; a++) begin
      if (a != 8'h11) rd_chk("count", a[7:0], 8'h00);
    end
    rd_chk("seq result", SEQUENCE_TEST_RESULT_OFS, 8'h00);
    rd_chk("unmapped", 8'h40, UNMAPPED_VAL);
    rd_chk("rsvd a", RESERVED_A_OFS, RESERVED_A_VAL);
    rd_chk("part id", PART_IDENTIFIER_OFS, PART_ID_DEFAULT);
    rd_chk("protection_capability rev", CAPABILITY_AND_REVISION_OFS, {4'h0, REVISION_DEFAULT});
    $display("test reset done");
  endtask

  task automatic t_thresholds;
    dss_host_model_i.wr(DETECTED_ERROR_THRESHOLD_OFS, 8'hA5);
    dss_host_model_i.wr(CORRECTED_ERROR_THRESHOLD_OFS, 8'h5A);
    check("det thr out", 8'hA5, det_thr);
    check("cor thr out", 8'h5A, cor_thr);
    rd_chk("det thr", DETECTED_ERROR_THRESHOLD_OFS, 8'hA5);
    rd_chk("cor thr", CORRECTED_ERROR_THRESHOLD_OFS, 8'h5A);
    $display("test thresholds done");
  endtask

  task automatic t_pins;
    dss_host_model_i.wr(AUX_PIN_CONTROL_LOW_OFS, 8'hFD);
    check("pin0 drive", 8'h00, {7'h00, drv});
    rd_chk("pin reg", AUX_PIN_CONTROL_LOW_OFS, 8'h00);
    @(posedge clk);
    pin1 <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("pin1 high", AUX_PIN_CONTROL_LOW_OFS, 8'h04);
    @(posedge clk);
    pin0 <= 1'b1;
    pin1 <= 1'b0;
    dss_host_model_i.wr(AUX_PIN_CONTROL_LOW_OFS, 8'h02);
    repeat (4) @(posedge clk);
    rd_chk("pin0 high", AUX_PIN_CONTROL_LOW_OFS, 8'h03);
    $display("test pins done");
  endtask

  task automatic t_counters;
    dss_host_model_i.wr(DETECTED_ERROR_THRESHOLD_OFS, 8'h03);
    pulse(0, 3);
    pulse(1, 2);
    pulse(2, 1);
    for (int a = 8'h10; a <= 8'h13; a++) dss_host_model_i.wr(a[7:0], 8'h55);
    rd_chk("det count", DETECTED_ERROR_COUNT_OFS, 8'h03);
    rd_chk("cor count", CORRECTED_ERROR_COUNT_OFS, 8'h02);
    rd_chk("seq count", SEQUENCE_ERROR_COUNT_OFS, 8'h01);
    rd_chk("det thr kept", DETECTED_ERROR_THRESHOLD_OFS, 8'h03);
    rd_chk("cor thr", CORRECTED_ERROR_THRESHOLD_OFS, 8'h55);
    check("det over", 8'h01, {7'h00, det_over});
    check("cor over", 8'h00, {7'h00, cor_over});
    $display("test counters done");
  endtask

  task automatic t_result_straps;
    @(posedge clk);
    seq_ok <= 1'b1;
    strap <= 4'hA;
    repeat (4) @(posedge clk);
    rd_chk("seq passed", SEQUENCE_TEST_RESULT_OFS, 8'h80);
    rd_chk("straps a", STRAP_PIN_STATUS_OFS, 8'hA0);
    @(posedge clk);
    seq_ok <= 1'b0;
    strap <= 4'h5;
    repeat (4) @(posedge clk);
    rd_chk("seq idle", SEQUENCE_TEST_RESULT_OFS, 8'h00);
    rd_chk("straps b", STRAP_PIN_STATUS_OFS, 8'h50);
    $display("test result and straps done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Tests need well under a thousand cycles
  initial begin
    #(8 * 20000);
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_thresholds();
    t_pins();
    t_counters();
    t_result_straps();
    wrap_up();
  end
endmodule

`default_nettype wire
